// [sim/csrf_core_model.sv]
// core-side sequencer model: turns one operation code into event strobes
module csrf_core_model (
  input wire logic [3:0] i_op,
  output logic [9:0] o_strb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  // code 4'hb raises exception and nmi in the same cycle
  always_comb begin
    o_strb = 10'h000;
    if (i_op == 4'hb) begin
      o_strb = 10'h00c;
    end else if (i_op != 4'h0) begin
      o_strb = 10'h001 << (i_op - 4'h1);
    end
  end
endmodule

// [sim/csrf_sysreg_file_tb_top.sv]
// self-checking bench for the system register file
module csrf_sysreg_file_tb_top
  import csrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------
  logic clk, rst, en, hold, dopen, rvalid, fault, ex_v, ex_f, m_open;
  logic [3:0] op;
  logic [9:0] strb;
  logic [4:0] num;
  logic [31:0] a_val, b_val, pc, program_status_word, base, rdata, m_pc, ex_d, seed;
  logic [31:0] m [0:31];
  int fail_count, n_tests;
  csrf_core_model i_core (.i_op(op), .o_strb(strb));
  csrf_sysreg_file i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_clk_en(en),
    .i_pc_load(strb[1]), .i_pc_load_addr(a_val),
    .i_pc_add(strb[0]), .i_pc_add_val(a_val),
    .i_next_pc(b_val), .i_exc_take(strb[2]), .i_nmi_take(strb[3]),
    .i_exc_code(~a_val), .i_table_call(strb[4]),
    .i_interrupt_return(strb[5]), .i_debug_trap(strb[6]),
    .i_debug_return(strb[7]), .i_load_system_register_en(strb[8]), .i_load_system_register_num(num),
    .i_load_system_register_data(b_val), .i_store_system_register_en(strb[9]), .i_store_system_register_num(num),
    .o_pc(pc), .o_psw(program_status_word), .o_table_call_base(base),
    .o_store_system_register_data(rdata), .o_store_system_register_valid(rvalid), .o_sr_fault(fault),
    .o_irq_hold(hold), .o_debug_open(dopen)
  );
  always #2 clk = ~clk;
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // stored width of each register number
  function automatic logic [31:0] fit(input logic [4:0] n,
                                      input logic [31:0] d);
    case (n)
      5'h00, 5'h02, 5'h10, 5'h12: fit = {6'h00, d[25:0]};
      5'h01, 5'h03, 5'h05, 5'h11, 5'h13: fit = {24'h000000, d[7:0]};
      default: fit = d;
    endcase
  endfunction
  function automatic logic ok(input logic [4:0] n, input logic dbg);
    ok = (n <= 5'h05 || (n >= 5'h10 && n <= 5'h14)) &&
         (dbg || !(n == SR_DBG_PC || n == SR_DBG_ST));
  endfunction
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_bit(input logic g, input logic x);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic reset_dut;
    @(negedge clk);
    rst = 1'b1;
    op = 4'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 32; i++) begin
      m[i] = 32'h00000000;
    end
    m_pc = 32'h00000000;
    m_open = 1'b0;
    ex_v = 1'b0;
    ex_f = 1'b0;
  endtask
  // ----------------------------------------------------------
  // one cycle: check last results, drive, advance the model
  // ----------------------------------------------------------
  task automatic do_op(input logic [3:0] o, input logic [31:0] a,
                       input logic [31:0] b, input logic [4:0] n,
                       input logic e);
    logic [31:0] ps;
    @(negedge clk);
    chk_word(pc, m_pc);
    chk_word(program_status_word, m[5]);
    chk_word(base, m[20]);
    chk_bit(dopen, m_open);
    chk_bit(rvalid, ex_v);
    chk_bit(fault, ex_f);
    if (ex_v) begin
      chk_word(rdata, ex_d);
    end
    op = o;
    a_val = a;
    b_val = b;
    num = n;
    en = e;
    #1;
    chk_bit(hold, o == 4'h9 && n == SR_PSW);
    ps = m[5];
    if (e) begin
      // a frozen cycle keeps the last read answer and fault standing
      ex_v = 1'b0;
      ex_f = 1'b0;
      case (o)
        4'h1: m_pc = {6'h00, m_pc[25:0] + a[25:0]} & 32'h03fffffe;
        4'h2: m_pc = {6'h00, a[25:1], 1'b0};
        4'h5: begin
          m[16] = fit(SR_TC_PC, b);
          m[17] = ps;
        end
        4'h6: begin
          m_pc = {6'h00, m[0][25:1], 1'b0};
          m[5] = m[1];
        end
        4'h7: m_open = 1'b1;
        4'h8: m_open = 1'b0;
        4'h9: begin
          ex_f = !ok(n, m_open);
          if (!ex_f && n != SR_CAUSE) begin
            m[n] = fit(n, b);
          end
        end
        4'ha: begin
          ex_v = 1'b1;
          ex_f = !ok(n, m_open);
          ex_d = ex_f ? 32'h00000000 : m[n];
        end
        default: ;
      endcase
      if (o == 4'h3 || o == 4'hb) begin
        m[0] = fit(SR_INT_PC, b);
        m[1] = ps;
        m[4] = ~a;
      end
      if (o == 4'h4 || o == 4'hb) begin
        m[2] = fit(SR_NMI_PC, b);
        m[3] = ps;
        m[4] = ~a;
        m[5][NMI_FLAG_BIT] = 1'b1;
      end
    end
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [3:0] o, prev;
    logic [31:0] a;
    clk = 1'b0;
    rst = 1'b1;
    en = 1'b1;
    op = 4'h0;
    num = 5'h00;
    a_val = 32'h00000000;
    b_val = 32'h00000000;
    fail_count = 0;
    n_tests = 0;
    seed = 32'h0000f96b;
    reset_dut();
    do_op(4'h2, 32'hfc3ffffd, 32'h0, 5'h00, 1'b1);
    do_op(4'h1, 32'hff000008, 32'h0, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'hffffffff, 5'h05, 1'b1);
    do_op(4'h3, 32'h1234, 32'hfffffff7, 5'h00, 1'b1);
    do_op(4'ha, 32'h0, 32'h0, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'h00000101, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'h00000022, 5'h01, 1'b1);
    do_op(4'h6, 32'h0, 32'h0, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'hffffffff, 5'h04, 1'b1);
    do_op(4'h4, 32'h77, 32'h88, 5'h00, 1'b1);
    do_op(4'hb, 32'h55, 32'h66, 5'h00, 1'b1);
    do_op(4'h5, 32'h0, 32'hfc000031, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'hffffffff, 5'h14, 1'b1);
    do_op(4'h9, 32'h0, 32'h1234567, 5'h12, 1'b1);
    for (int i = 0; i < 32; i++) begin
      do_op(4'ha, 32'h0, 32'h0, i[4:0], 1'b1);
    end
    do_op(4'h7, 32'h0, 32'h0, 5'h00, 1'b1);
    do_op(4'h9, 32'h0, 32'h3fffffff, 5'h12, 1'b1);
    do_op(4'h9, 32'h0, 32'hffffffff, 5'h13, 1'b1);
    do_op(4'ha, 32'h0, 32'h0, 5'h12, 1'b1);
    do_op(4'ha, 32'h0, 32'h0, 5'h13, 1'b1);
    do_op(4'h8, 32'h0, 32'h0, 5'h00, 1'b1);
    do_op(4'ha, 32'h0, 32'h0, 5'h12, 1'b1);
    do_op(4'h0, 32'h0, 32'h0, 5'h00, 1'b1);
    do_op(4'h1, 32'h4, 32'h0, 5'h00, 1'b0);
    $display("corner tests done");
    prev = 4'h0;
    for (int i = 0; i < 3000; i++) begin
      seed = xs(seed);
      o = (seed[3:0] > 4'hb) ? 4'ha : seed[3:0];
      a = xs(seed);
      do_op(o, a, xs(a), seed[8:4], !(seed[12:9] == 4'h0 && prev != 4'ha));
      prev = o;
    end
    $display("random tests done");
    reset_dut();
    do_op(4'h0, 32'h0, 32'h0, 5'h00, 1'b1);
    $display("reset test done");
    report_and_stop();
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule

// [src/csrf_pc_unit.sv]
// program counter with 26 valid bits and bit 0 held at zero
module csrf_pc_unit
  import csrf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_load,
  input wire logic [31:0] i_load_addr,
  input wire logic i_add,
  input wire logic [31:0] i_add_val,
  output logic [31:0] o_pc
);

  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] sum;

  // carry out of bit 25 falls off the 26-bit sum
  assign sum = pc_r + i_add_val[PC_W-1:0];

  always_comb begin
    pc_nxt = pc_r;
    if (i_load) begin
      pc_nxt = {i_load_addr[PC_W-1:1], 1'b0};
    end else if (i_add) begin
      pc_nxt = {sum[PC_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pc_r <= RST_PC;
    end else if (i_clk_en) begin
      pc_r <= pc_nxt;
    end
  end

  assign o_pc = {{(WORD_W-PC_W){1'b0}}, pc_r};

  chk_pc_even_wrap: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_clk_en && i_add && !i_load |=>
      o_pc == ({6'h00, $past(pc_r) + $past(i_add_val[PC_W-1:0])}
               & 32'h03fffffe))
    else $error("pc add did not wrap at 26 bits");

  chk_pc_upper_zero: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    o_pc[31:26] == 6'h00 && !o_pc[0])
    else $error("pc upper bits or bit 0 not zero");

endmodule

// [src/csrf_pkg.sv]
// shared constants, state type and decoding for the system register file
package csrf_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PC_W = 26;
  localparam int SW_W = 8;
  localparam int NUM_W = 5;
  localparam int WORD_W = 32;
  localparam int NMI_FLAG_BIT = 7;

  // ------------------------------------------------------------
  // system register numbers
  // ------------------------------------------------------------
  localparam logic [4:0] SR_INT_PC = 5'h00;
  localparam logic [4:0] SR_INT_ST = 5'h01;
  localparam logic [4:0] SR_NMI_PC = 5'h02;
  localparam logic [4:0] SR_NMI_ST = 5'h03;
  localparam logic [4:0] SR_CAUSE = 5'h04;
  localparam logic [4:0] SR_PSW = 5'h05;
  localparam logic [4:0] SR_TC_PC = 5'h10;
  localparam logic [4:0] SR_TC_ST = 5'h11;
  localparam logic [4:0] SR_DBG_PC = 5'h12;
  localparam logic [4:0] SR_DBG_ST = 5'h13;
  localparam logic [4:0] SR_TC_BASE = 5'h14;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [25:0] RST_PC = 26'h0000000;
  localparam logic [7:0] RST_PSW = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // ------------------------------------------------------------
  // debug access window
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DBG_IDLE = 2'b01,
    DBG_OPEN = 2'b10
  } csrf_dbg_state_t;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  function automatic logic csrf_is_debug(input logic [4:0] num);
    return (num == SR_DBG_PC) || (num == SR_DBG_ST);
  endfunction

  function automatic logic csrf_is_impl(input logic [4:0] num);
    return (num <= SR_PSW) || ((num >= SR_TC_PC) && (num <= SR_TC_BASE));
  endfunction

endpackage

// [src/csrf_sr_read_mux.sv]
// selects a system register by number for a store-system-register read
module csrf_sr_read_mux
  import csrf_pkg::*;
(
  input wire logic [4:0] i_num,
  input wire logic i_debug_open,
  input wire logic [25:0] i_int_pc,
  input wire logic [7:0] i_int_st,
  input wire logic [25:0] i_nmi_pc,
  input wire logic [7:0] i_nmi_st,
  input wire logic [31:0] i_cause,
  input wire logic [7:0] i_psw,
  input wire logic [25:0] i_tc_pc,
  input wire logic [7:0] i_tc_st,
  input wire logic [25:0] i_dbg_pc,
  input wire logic [7:0] i_dbg_st,
  input wire logic [31:0] i_tc_base,
  output logic [31:0] o_data,
  output logic o_ok
);

  logic [31:0] pc_ext;
  logic [31:0] st_ext;

  always_comb begin
    o_data = RST_WORD;
    o_ok = csrf_is_impl(i_num) &&
           !(csrf_is_debug(i_num) && !i_debug_open);
    case (i_num)
      SR_INT_PC: o_data = {6'h00, i_int_pc};
      SR_INT_ST: o_data = {24'h000000, i_int_st};
      SR_NMI_PC: o_data = {6'h00, i_nmi_pc};
      SR_NMI_ST: o_data = {24'h000000, i_nmi_st};
      SR_CAUSE: o_data = i_cause;
      SR_PSW: o_data = {24'h000000, i_psw};
      SR_TC_PC: o_data = {6'h00, i_tc_pc};
      SR_TC_ST: o_data = {24'h000000, i_tc_st};
      SR_DBG_PC: o_data = {6'h00, i_dbg_pc};
      SR_DBG_ST: o_data = {24'h000000, i_dbg_st};
      SR_TC_BASE: o_data = i_tc_base;
      default: o_data = RST_WORD;
    endcase
    if (!o_ok) begin
      o_data = RST_WORD;
    end
  end

endmodule

// [src/csrf_sysreg_file.sv]
// program counter and system register set with context save and restore
// Function
// - only 26 pc bits, upper bits zero
// - carry out of bit 25 discarded
// - pc bit 0 always zero
// - register chosen by number in instruction
// - numbers 0-3 and 5 readable, writable
// - number 4 cause register, read only
// - numbers 16 to 20 readable, writable
// - debug pair only open inside debug window
// - restored pc bit 0 ignored on return
// - exception or interrupt saves pc and status
// - saved pc is next instruction address
// - interrupt pair upper bits read zero
// - interrupt return restores pc and status
// - nmi saves into the nmi pair
// - nmi saved pc is next instruction
// - nmi pair upper bits read zero
// - cause register loaded on exception and nmi only
// - status write effective next, holds interrupts
// - status word bits 31 to 8 zero
// - nmi acceptance sets status bit 7
// - table call saves next pc, status
module csrf_sysreg_file
  import csrf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_pc_load,
  input wire logic [31:0] i_pc_load_addr,
  input wire logic i_pc_add,
  input wire logic [31:0] i_pc_add_val,
  input wire logic [31:0] i_next_pc,
  input wire logic i_exc_take,
  input wire logic i_nmi_take,
  input wire logic [31:0] i_exc_code,
  input wire logic i_table_call,
  input wire logic i_interrupt_return,
  input wire logic i_debug_trap,
  input wire logic i_debug_return,
  input wire logic i_load_system_register_en,
  input wire logic [4:0] i_load_system_register_num,
  input wire logic [31:0] i_load_system_register_data,
  input wire logic i_store_system_register_en,
  input wire logic [4:0] i_store_system_register_num,
  output logic [31:0] o_pc,
  output logic [31:0] o_psw,
  output logic [31:0] o_table_call_base,
  output logic [31:0] o_store_system_register_data,
  output logic o_store_system_register_valid,
  output logic o_sr_fault,
  output logic o_irq_hold,
  output logic o_debug_open
);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [PC_W-1:0] int_pc_r;
  logic [SW_W-1:0] int_st_r;
  logic [PC_W-1:0] nmi_pc_r;
  logic [SW_W-1:0] nmi_st_r;
  logic [WORD_W-1:0] cause_r;
  logic [SW_W-1:0] psw_r;
  logic [SW_W-1:0] psw_nxt;
  logic [PC_W-1:0] tc_pc_r;
  logic [SW_W-1:0] tc_st_r;
  logic [PC_W-1:0] dbg_pc_r;
  logic [SW_W-1:0] dbg_st_r;
  logic [WORD_W-1:0] tc_base_r;
  csrf_dbg_state_t dbg_state_r;
  csrf_dbg_state_t dbg_state_nxt;
  logic [31:0] store_system_register_data_r;
  logic store_system_register_valid_r;
  logic fault_r;

  logic debug_open;
  logic wr_ok;
  logic wr_int_pc;
  logic wr_int_st;
  logic wr_nmi_pc;
  logic wr_nmi_st;
  logic wr_psw;
  logic wr_tc_pc;
  logic wr_tc_st;
  logic wr_dbg_pc;
  logic wr_dbg_st;
  logic wr_tc_base;
  logic [31:0] rd_data;
  logic rd_ok;
  logic pc_restore;
  logic [31:0] pc_load_addr;

  // ------------------------------------------------------------
  // debug access window
  // ------------------------------------------------------------
  always_comb begin
    dbg_state_nxt = dbg_state_r;
    case (dbg_state_r)
      DBG_IDLE: begin
        if (i_debug_trap) begin
          dbg_state_nxt = DBG_OPEN;
        end
      end
      DBG_OPEN: begin
        if (i_debug_return) begin
          dbg_state_nxt = DBG_IDLE;
        end
      end
      default: dbg_state_nxt = DBG_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dbg_state_r <= DBG_IDLE;
    end else if (i_clk_en) begin
      dbg_state_r <= dbg_state_nxt;
    end
  end

  assign debug_open = (dbg_state_r == DBG_OPEN);
  assign o_debug_open = debug_open;

  // ------------------------------------------------------------
  // load-system-register write decode
  // ------------------------------------------------------------
  // reserved numbers and the cause register take no write
  assign wr_ok = i_load_system_register_en && csrf_is_impl(i_load_system_register_num) &&
                 (i_load_system_register_num != SR_CAUSE) &&
                 !(csrf_is_debug(i_load_system_register_num) && !debug_open);
  assign wr_int_pc = wr_ok && (i_load_system_register_num == SR_INT_PC);
  assign wr_int_st = wr_ok && (i_load_system_register_num == SR_INT_ST);
  assign wr_nmi_pc = wr_ok && (i_load_system_register_num == SR_NMI_PC);
  assign wr_nmi_st = wr_ok && (i_load_system_register_num == SR_NMI_ST);
  assign wr_psw = wr_ok && (i_load_system_register_num == SR_PSW);
  assign wr_tc_pc = wr_ok && (i_load_system_register_num == SR_TC_PC);
  assign wr_tc_st = wr_ok && (i_load_system_register_num == SR_TC_ST);
  assign wr_dbg_pc = wr_ok && (i_load_system_register_num == SR_DBG_PC);
  assign wr_dbg_st = wr_ok && (i_load_system_register_num == SR_DBG_ST);
  assign wr_tc_base = wr_ok && (i_load_system_register_num == SR_TC_BASE);

  // interrupts wait while the status word is being written
  assign o_irq_hold = i_load_system_register_en && (i_load_system_register_num == SR_PSW);

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  assign pc_restore = i_interrupt_return;
  assign pc_load_addr = pc_restore ? {6'h00, int_pc_r} : i_pc_load_addr;

  csrf_pc_unit u_pc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_load(pc_restore || i_pc_load),
    .i_load_addr(pc_load_addr),
    .i_add(i_pc_add),
    .i_add_val(i_pc_add_val),
    .o_pc(o_pc)
  );

  // ------------------------------------------------------------
  // interrupt save pair
  // ------------------------------------------------------------
  // a hardware save wins over a same-cycle software write
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      int_pc_r <= RST_PC;
      int_st_r <= RST_PSW;
    end else if (i_clk_en) begin
      if (i_exc_take) begin
        int_pc_r <= i_next_pc[PC_W-1:0];
        int_st_r <= psw_r;
      end else begin
        if (wr_int_pc) begin
          int_pc_r <= i_load_system_register_data[PC_W-1:0];
        end
        if (wr_int_st) begin
          int_st_r <= i_load_system_register_data[SW_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // nmi save pair
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      nmi_pc_r <= RST_PC;
      nmi_st_r <= RST_PSW;
    end else if (i_clk_en) begin
      if (i_nmi_take) begin
        nmi_pc_r <= i_next_pc[PC_W-1:0];
        nmi_st_r <= psw_r;
      end else begin
        if (wr_nmi_pc) begin
          nmi_pc_r <= i_load_system_register_data[PC_W-1:0];
        end
        if (wr_nmi_st) begin
          nmi_st_r <= i_load_system_register_data[SW_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // exception cause
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cause_r <= RST_WORD;
    end else if (i_clk_en && (i_exc_take || i_nmi_take)) begin
      cause_r <= i_exc_code;
    end
  end

  // ------------------------------------------------------------
  // program status word
  // ------------------------------------------------------------
  always_comb begin
    psw_nxt = psw_r;
    if (i_interrupt_return) begin
      psw_nxt = int_st_r;
    end else if (i_nmi_take) begin
      psw_nxt[NMI_FLAG_BIT] = 1'b1;
    end else if (wr_psw) begin
      psw_nxt = i_load_system_register_data[SW_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      psw_r <= RST_PSW;
    end else if (i_clk_en) begin
      psw_r <= psw_nxt;
    end
  end

  assign o_psw = {24'h000000, psw_r};

  // ------------------------------------------------------------
  // table call pair and base
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tc_pc_r <= RST_PC;
      tc_st_r <= RST_PSW;
    end else if (i_clk_en) begin
      if (i_table_call) begin
        tc_pc_r <= i_next_pc[PC_W-1:0];
        tc_st_r <= psw_r;
      end else begin
        if (wr_tc_pc) begin
          tc_pc_r <= i_load_system_register_data[PC_W-1:0];
        end
        if (wr_tc_st) begin
          tc_st_r <= i_load_system_register_data[SW_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tc_base_r <= RST_WORD;
    end else if (i_clk_en && wr_tc_base) begin
      tc_base_r <= i_load_system_register_data;
    end
  end

  assign o_table_call_base = tc_base_r;

  // ------------------------------------------------------------
  // debug save pair
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dbg_pc_r <= RST_PC;
      dbg_st_r <= RST_PSW;
    end else if (i_clk_en) begin
      if (wr_dbg_pc) begin
        dbg_pc_r <= i_load_system_register_data[PC_W-1:0];
      end
      if (wr_dbg_st) begin
        dbg_st_r <= i_load_system_register_data[SW_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // store-system-register read
  // ------------------------------------------------------------
  csrf_sr_read_mux u_rd (
    .i_num(i_store_system_register_num),
    .i_debug_open(debug_open),
    .i_int_pc(int_pc_r),
    .i_int_st(int_st_r),
    .i_nmi_pc(nmi_pc_r),
    .i_nmi_st(nmi_st_r),
    .i_cause(cause_r),
    .i_psw(psw_r),
    .i_tc_pc(tc_pc_r),
    .i_tc_st(tc_st_r),
    .i_dbg_pc(dbg_pc_r),
    .i_dbg_st(dbg_st_r),
    .i_tc_base(tc_base_r),
    .o_data(rd_data),
    .o_ok(rd_ok)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      store_system_register_data_r <= RST_WORD;
      store_system_register_valid_r <= 1'b0;
    end else if (i_clk_en) begin
      store_system_register_valid_r <= i_store_system_register_en;
      if (i_store_system_register_en) begin
        store_system_register_data_r <= rd_data;
      end
    end
  end

  // refused access to a reserved or closed number
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fault_r <= 1'b0;
    end else if (i_clk_en) begin
      fault_r <= (i_load_system_register_en && !wr_ok && (i_load_system_register_num != SR_CAUSE)) ||
                 (i_store_system_register_en && !rd_ok);
    end
  end

  assign o_store_system_register_data = store_system_register_data_r;
  assign o_store_system_register_valid = store_system_register_valid_r;
  assign o_sr_fault = fault_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_exc_save_pair: assert property (
    i_clk_en && i_exc_take |=>
      int_pc_r == $past(i_next_pc[PC_W-1:0]) && int_st_r == $past(psw_r))
    else $error("interrupt pair not saved on exception");

  chk_nmi_save_flag: assert property (
    i_clk_en && i_nmi_take && !i_interrupt_return |=>
      nmi_st_r == $past(psw_r) && o_psw[NMI_FLAG_BIT] &&
      nmi_pc_r == $past(i_next_pc[PC_W-1:0]))
    else $error("nmi pair or nmi flag wrong after nmi");

  chk_cause_read_only: assert property (
    i_clk_en && i_load_system_register_en && i_load_system_register_num == SR_CAUSE &&
    !i_exc_take && !i_nmi_take |=> $stable(cause_r))
    else $error("cause register changed by a software write");

  chk_cause_load: assert property (
    i_clk_en && (i_exc_take || i_nmi_take) |=>
      cause_r == $past(i_exc_code))
    else $error("cause register not loaded on event");

  chk_interrupt_return_restore: assert property (
    i_clk_en && i_interrupt_return |=>
      o_pc == ({6'h00, $past(int_pc_r)} & 32'hfffffffe) &&
      psw_r == $past(int_st_r))
    else $error("interrupt return did not restore pc and status");

  chk_debug_gate: assert property (
    i_clk_en && !debug_open && i_load_system_register_en &&
    csrf_is_debug(i_load_system_register_num) |=> $stable(dbg_pc_r) && $stable(dbg_st_r))
    else $error("debug pair written outside debug window");

  chk_psw_write_next: assert property (
    i_clk_en && wr_psw && !i_interrupt_return && !i_nmi_take |=>
      o_psw == {24'h000000, $past(i_load_system_register_data[SW_W-1:0])})
    else $error("status word write not effective next cycle");

  chk_table_call_save: assert property (
    i_clk_en && i_table_call |=>
      tc_pc_r == $past(i_next_pc[PC_W-1:0]) && tc_st_r == $past(psw_r))
    else $error("table call pair not saved");

  chk_store_system_register_reserved: assert property (
    i_clk_en && i_store_system_register_en && !csrf_is_impl(i_store_system_register_num) |=>
      o_store_system_register_valid && o_store_system_register_data == 32'h00000000 && o_sr_fault)
    else $error("reserved read did not return zero with fault");

  chk_psw_upper_zero: assert property (
    o_psw[31:8] == 24'h000000 && o_store_system_register_valid == $past(i_store_system_register_en) ||
    !$past(i_clk_en))
    else $error("status word upper bits not zero");

endmodule
